// ---- core/apsc_map.svh ----
`ifndef APSC_MAP_SVH
`define APSC_MAP_SVH

// ==========================================================================
// Register indices; byte address is four times the index.
`define APSC_IDX_RENEW 8'h62
`define APSC_IDX_STATUS 8'h64
`define APSC_IDX_TURN 8'h66
`define APSC_IDX_SINGLE 8'h68
`define APSC_IDX_FTIME 8'h6a
`define APSC_IDX_LOWER 8'h6c
`define APSC_IDX_UPPER 8'h6e
`define APSC_IDX_UNITSEL 8'h70
`define APSC_IDX_IRQSTAT 8'h71
`define APSC_IDX_IRQMASK 8'h72
`define APSC_IDX_FILTOUT 8'h73

// ==========================================================================
// Command values, field positions and widths.
`define APSC_RENEW_REFRESH 16'h0001
`define APSC_RENEW_CLEAR 16'h0002
`define APSC_UNIT_BIT 1
`define APSC_UNIT_USER 1'h1
`define APSC_FTIME_W 4
`define APSC_STATUS_W 5
`define APSC_IRQ_W 4
`define APSC_IRQ_RENEW 0
`define APSC_IRQ_FILT 1
`define APSC_IRQ_LOST 2
`define APSC_IRQ_BATT 3
`define APSC_ADDR_LSB 2'h0
`define APSC_ZERO32 32'h0000_0000

// ==========================================================================
// Timing: filter unit is one millisecond, clock period 25 ns.
`define APSC_MS_NS 1000000
`define APSC_CLK_NS 25

`endif

// ---- core/apsc_pkg.sv ----
package apsc_pkg;

  // Range-compare filter states.
  typedef enum logic [1:0] {
    FLT_PASS,
    FLT_COUNT,
    FLT_OPEN
  } apsc_flt_t;

  // APB request from the master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } apsc_apb_req_t;

  // APB answer to the master.
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apsc_apb_rsp_t;

  // Live encoder and position data from the drive core.
  typedef struct packed {
    logic absLost;
    logic battLow;
    logic turnOvf;
    logic puuOvf;
    logic coordUnset;
    logic [15:0] turns;
    logic [31:0] pulse;
    logic [31:0] userPos;
  } apsc_enc_t;

  // Pulses toward the position loop.
  typedef struct packed {
    logic posErrClear;
    logic loadTarget;
  } apsc_cmd_t;

  // All state of the block.
  typedef struct packed {
    apsc_apb_rsp_t rsp;
    apsc_cmd_t cmd;
    logic irq;
    logic [4:0] status;
    logic [15:0] turn;
    logic [31:0] single;
    logic [3:0] ftime;
    logic [31:0] lower;
    logic [31:0] upper;
    logic unitUser;
    logic [3:0] irqStat;
    logic [3:0] irqMask;
    apsc_flt_t flt;
    logic [31:0] msCnt;
    logic [3:0] msDone;
    logic [31:0] filtOut;
    logic prevLost;
    logic prevBatt;
  } apsc_state_t;

endpackage : apsc_pkg

// ---- core/apsc_top.sv ----
`timescale 1ns/100ps
`include "apsc_map.svh"

module apsc_top #(
  parameter int MS_CYCLES = `APSC_MS_NS / `APSC_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire apsc_pkg::apsc_apb_req_t apbReq,
  output apsc_pkg::apsc_apb_rsp_t apbRsp,
  input wire apsc_pkg::apsc_enc_t enc,
  input wire logic [31:0] monVar,
  output logic [31:0] filtOut,
  output apsc_pkg::apsc_cmd_t cmd,
  output logic irq
);
  import apsc_pkg::*;

  // ========================================================================
  // Decode helpers.

  // True for every index that answers on the bus.
  function automatic logic regMapped(input logic [7:0] idx);
    logic hit;
    hit = 1'b0;
    if (idx == `APSC_IDX_RENEW) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_STATUS) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_TURN) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_SINGLE) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_FTIME) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_LOWER) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_UPPER) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_UNITSEL) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_IRQSTAT) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_IRQMASK) begin
      hit = 1'b1;
    end else if (idx == `APSC_IDX_FILTOUT) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : regMapped

  // Read value of one register; narrow registers zero-fill the top bits, except TURN, which sign-extends bit 15 in pulse units and is zero in user units.
  function automatic logic [31:0] readReg(input logic [7:0] idx,
                                          input apsc_state_t s);
    logic [31:0] v;
    v = `APSC_ZERO32;
    if (idx == `APSC_IDX_STATUS) begin
      v = {27'h0000000, s.status};
    end else if (idx == `APSC_IDX_TURN) begin
      if (s.unitUser == `APSC_UNIT_USER) begin
        v = `APSC_ZERO32;
      end else begin
        v = {{16{s.turn[15]}}, s.turn};
      end
    end else if (idx == `APSC_IDX_SINGLE) begin
      v = s.single;
    end else if (idx == `APSC_IDX_FTIME) begin
      v = {28'h0000000, s.ftime};
    end else if (idx == `APSC_IDX_LOWER) begin
      v = s.lower;
    end else if (idx == `APSC_IDX_UPPER) begin
      v = s.upper;
    end else if (idx == `APSC_IDX_UNITSEL) begin
      v = {30'h00000000, s.unitUser, 1'b0};
    end else if (idx == `APSC_IDX_IRQSTAT) begin
      v = {28'h0000000, s.irqStat};
    end else if (idx == `APSC_IDX_IRQMASK) begin
      v = {28'h0000000, s.irqMask};
    end else if (idx == `APSC_IDX_FILTOUT) begin
      v = s.filtOut;
    end
    return v;
  endfunction : readReg

  // Signed inclusive window test; an inverted window never matches.
  function automatic logic inRange(input logic [31:0] v,
                                   input logic [31:0] lo,
                                   input logic [31:0] hi);
    return ($signed(v) >= $signed(lo)) && ($signed(v) <= $signed(hi));
  endfunction : inRange

  // ========================================================================
  // Reset release.

  logic [1:0] rstPipe;
  logic rstSync_n;

  // The reset asserts at once and is released through two flip-flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstSync_n = rstPipe[1];

  // ========================================================================
  // Bus phase decode.

  // Declared here because the bus decode reads the registered pready.
  apsc_state_t st_reg;
  apsc_state_t st_next;
  logic [7:0] busIdx;
  logic busOk;
  logic setupPh;
  logic accessPh;
  logic wrHit;
  logic [15:0] wrLow;
  logic [31:0] msLast;

  assign busIdx = apbReq.paddr[9:2];
  assign busOk = regMapped(busIdx) && (apbReq.paddr[1:0] == `APSC_ADDR_LSB);
  assign setupPh = apbReq.psel && !apbReq.penable;
  // Completion is the edge where our own pready is seen high.
  assign accessPh = apbReq.psel && apbReq.penable && st_reg.rsp.pready;
  assign wrHit = accessPh && apbReq.pwrite && busOk;
  assign wrLow = apbReq.pwdata[15:0];
  assign msLast = 32'(MS_CYCLES - 1);

  // ========================================================================
  // State.

  logic [3:0] irqEv;
  logic [3:0] irqClr;
  logic inWin;
  logic renewHit;

  assign inWin = inRange(monVar, st_reg.lower, st_reg.upper);
  assign renewHit = wrHit && (busIdx == `APSC_IDX_RENEW) &&
                    ((wrLow == `APSC_RENEW_REFRESH) ||
                     (wrLow == `APSC_RENEW_CLEAR));

  // Next-state logic for the whole block.
  always_comb begin
    st_next = st_reg;
    st_next.cmd = '0;
    irqEv = 4'h0;
    irqClr = 4'h0;

    // Status flags follow the drive core every cycle.
    st_next.status[0] = enc.absLost;
    st_next.status[1] = enc.battLow;
    st_next.status[2] = enc.turnOvf;
    st_next.status[3] = enc.puuOvf;
    st_next.status[4] = enc.coordUnset;
    st_next.prevLost = enc.absLost;
    st_next.prevBatt = enc.battLow;
    irqEv[`APSC_IRQ_LOST] = enc.absLost && !st_reg.prevLost;
    irqEv[`APSC_IRQ_BATT] = enc.battLow && !st_reg.prevBatt;

    // The answer is prepared in the setup cycle so that it leaves a flop.
    if (setupPh) begin
      st_next.rsp.prdata = busOk ? readReg(busIdx, st_reg) : `APSC_ZERO32;
      st_next.rsp.pslverr = !busOk;
      st_next.rsp.pready = 1'b1;
    end else if (accessPh) begin
      st_next.rsp.pready = 1'b0;
      st_next.rsp.pslverr = 1'b0;
    end

    // Register writes take effect at the completing edge only.
    if (wrHit) begin
      if (busIdx == `APSC_IDX_FTIME) begin
        st_next.ftime = apbReq.pwdata[`APSC_FTIME_W-1:0];
      end else if (busIdx == `APSC_IDX_LOWER) begin
        st_next.lower = apbReq.pwdata;
      end else if (busIdx == `APSC_IDX_UPPER) begin
        st_next.upper = apbReq.pwdata;
      end else if (busIdx == `APSC_IDX_UNITSEL) begin
        st_next.unitUser = apbReq.pwdata[`APSC_UNIT_BIT];
      end else if (busIdx == `APSC_IDX_IRQSTAT) begin
        irqClr = apbReq.pwdata[`APSC_IRQ_W-1:0];
      end else if (busIdx == `APSC_IDX_IRQMASK) begin
        st_next.irqMask = apbReq.pwdata[`APSC_IRQ_W-1:0];
      end
    end

    // Renew snapshots encoder data; value 2 also resets the position loop.
    if (renewHit) begin
      st_next.turn = enc.turns;
      if (st_reg.unitUser == `APSC_UNIT_USER) begin
        st_next.single = enc.userPos;
      end else begin
        st_next.single = enc.pulse;
      end
      irqEv[`APSC_IRQ_RENEW] = 1'b1;
      if (wrLow == `APSC_RENEW_CLEAR) begin
        st_next.cmd.posErrClear = 1'b1;
        st_next.cmd.loadTarget = 1'b1;
      end
    end

    // Range-compare filter; outside the window and once released, the output lags the input by one cycle.
    case (st_reg.flt)
      FLT_PASS: begin
        if (inWin) begin
          st_next.msCnt = `APSC_ZERO32;
          st_next.msDone = 4'h0;
          if (st_reg.ftime == 4'h0) begin
            st_next.flt = FLT_OPEN;
            st_next.filtOut = monVar;
          end else begin
            st_next.flt = FLT_COUNT;
          end
        end else begin
          st_next.filtOut = monVar;
        end
      end
      FLT_COUNT: begin
        if (!inWin) begin
          st_next.flt = FLT_PASS;
          st_next.filtOut = monVar;
        end else if (st_reg.msCnt == msLast) begin
          st_next.msCnt = `APSC_ZERO32;
          st_next.msDone = st_reg.msDone + 4'h1;
          if ((st_reg.msDone + 4'h1) >= st_reg.ftime) begin
            st_next.flt = FLT_OPEN;
            st_next.filtOut = monVar;
            irqEv[`APSC_IRQ_FILT] = 1'b1;
          end
        end else begin
          st_next.msCnt = st_reg.msCnt + 32'h0000_0001;
        end
      end
      FLT_OPEN: begin
        st_next.filtOut = monVar;
        if (!inWin) begin
          st_next.flt = FLT_PASS;
        end
      end
      default: begin
        st_next.flt = FLT_PASS;
      end
    endcase

    // Sticky events: a set in the clearing cycle wins over the clear.
    st_next.irqStat = (st_reg.irqStat & ~irqClr) | irqEv;
    st_next.irq = |(st_next.irqStat & st_next.irqMask);
  end

  // One register for all state; clock enable low freezes this register, while the reset release keeps running.
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ========================================================================
  // Outputs, each taken straight from the state register.

  assign apbRsp = st_reg.rsp;
  assign filtOut = st_reg.filtOut;
  assign cmd = st_reg.cmd;
  assign irq = st_reg.irq;

endmodule : apsc_top

// ---- tb/apsc_assertions.sv ----
`timescale 1ns/100ps
`include "apsc_map.svh"
// ==================================
// Checker on the block's ports.
module apsc_checker #(
  parameter int MS_CYCLES = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire apsc_pkg::apsc_apb_req_t apbReq,
  input wire apsc_pkg::apsc_apb_rsp_t apbRsp,
  input wire apsc_pkg::apsc_enc_t enc,
  input wire logic [31:0] monVar,
  input wire logic [31:0] filtOut,
  input wire apsc_pkg::apsc_cmd_t cmd,
  input wire logic irq
);
  import apsc_pkg::*;
  logic [1:0] upReg;
  logic [3:0] ftReg;
  logic signed [31:0] loReg;
  logic signed [31:0] hiReg;
  logic done;
  logic wr;
  logic outR;
  // Completed transfers; limits are shadowed to know the window.
  assign done = ce && apbReq.psel && apbReq.penable && apbRsp.pready;
  assign wr = done && apbReq.pwrite;
  assign outR = $signed(monVar) < loReg || $signed(monVar) > hiReg;
  // Counting up skips the two internal reset cycles after release.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upReg <= 2'h0;
      ftReg <= 4'h0;
      loReg <= 32'h0;
      hiReg <= 32'h0;
    end else begin
      upReg <= (upReg == 2'h3) ? upReg : upReg + 2'h1;
      if (wr && apbReq.paddr == {`APSC_IDX_FTIME, 2'h0})
        ftReg <= apbReq.pwdata[3:0];
      if (wr && apbReq.paddr == {`APSC_IDX_LOWER, 2'h0})
        loReg <= apbReq.pwdata;
      if (wr && apbReq.paddr == {`APSC_IDX_UPPER, 2'h0})
        hiReg <= apbReq.pwdata;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence renewOf(v);
    wr && apbReq.paddr == {`APSC_IDX_RENEW, 2'h0}
      && apbReq.pwdata[15:0] == v;
  endsequence
  sequence readOf(a);
    done && !apbReq.pwrite && apbReq.paddr == {a, 2'h0};
  endsequence
  sequence entry;
    (upReg == 2'h3 && ce && outR) ##1 (ce && !outR && ftReg != 4'h0);
  endsequence
  chk_renew_plain:
    assert property (renewOf(16'h1) |=> !cmd.loadTarget && !cmd.posErrClear)
    else $error("renew one moved the loop");
  chk_renew_clear:
    assert property (renewOf(16'h2) |=> cmd.loadTarget && cmd.posErrClear)
    else $error("renew two gave no pulses");
  chk_pulse_once:
    assert property (cmd.loadTarget |=> !cmd.loadTarget && !cmd.posErrClear)
    else $error("loop pulse too long");
  chk_status_resv:
    assert property (readOf(`APSC_IDX_STATUS) |-> apbRsp.prdata[31:5] == 0)
    else $error("status reserved bits set");
  chk_turn_sext:
    assert property (readOf(`APSC_IDX_TURN)
      |-> apbRsp.prdata[31:16] == {16{apbRsp.prdata[15]}})
    else $error("turn count out of range");
  chk_ftime_resv:
    assert property (readOf(`APSC_IDX_FTIME) |-> apbRsp.prdata[31:4] == 0)
    else $error("filter time reserved bits set");
  chk_out_pass:
    assert property (upReg == 2'h3 && ce && outR
      |=> filtOut == $past(monVar))
    else $error("value outside window held");
  chk_entry_hold:
    assert property (entry |=> $stable(filtOut))
    else $error("value inside window not held");
endmodule : apsc_checker

bind apsc_top apsc_checker #(.MS_CYCLES(MS_CYCLES)) chkU (.clk(clk),
  .rst_n(rst_n), .ce(ce), .apbReq(apbReq), .apbRsp(apbRsp), .enc(enc),
  .monVar(monVar), .filtOut(filtOut), .cmd(cmd), .irq(irq));

// ---- tb/apsc_top_tb.sv ----
`timescale 1ns/100ps
`include "apsc_map.svh"
// ==================================
// Bench for the position status block.
module apsc_top_tb;
  import apsc_pkg::*;
  logic clk, rst_n, ce, irq, slvErr;
  apsc_apb_req_t apbReq;
  apsc_apb_rsp_t apbRsp;
  apsc_enc_t enc;
  apsc_cmd_t cmd;
  logic [31:0] monVar, filtOut, rdData;
  logic [31:0] pulseCnt = 0;
  int errorCnt = 0;
  int cmpCount = 0;
  apsc_top #(.MS_CYCLES(4)) dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .apbReq(apbReq), .apbRsp(apbRsp), .enc(enc), .monVar(monVar),
    .filtOut(filtOut), .cmd(cmd), .irq(irq));
  // Free running clock at 40 MHz.
  always #12.5 clk = ~clk;
  // Count paired loop pulses.
  always @(posedge clk)
    if (cmd.posErrClear === 1'b1 && cmd.loadTarget === 1'b1)
      pulseCnt <= pulseCnt + 1;
  task automatic chk(input string n, input logic [31:0] s, e);
    cmpCount++;
    if (s !== e) begin
      errorCnt++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // One transfer, held until pready is seen high.
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, {i, 2'h0}, d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rdData = apbRsp.prdata;
    slvErr = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : xfer
  task automatic rdc(input string n, input logic [7:0] i, input logic [31:0] e);
    xfer(1'b0, i, 32'h0);
    chk(n, rdData, e);
  endtask : rdc
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  // Reset values, reserved bits, a read-only write, an unmapped read.
  task automatic t_regs();
    rdc("ftime rst", `APSC_IDX_FTIME, 32'h0);
    rdc("lower rst", `APSC_IDX_LOWER, 32'h0);
    rdc("upper rst", `APSC_IDX_UPPER, 32'h0);
    xfer(1'b1, `APSC_IDX_FTIME, 32'hffff_ffff);
    rdc("ftime", `APSC_IDX_FTIME, 32'hf);
    xfer(1'b1, `APSC_IDX_STATUS, 32'hffff_ffff);
    rdc("status ro", `APSC_IDX_STATUS, 32'h0);
    xfer(1'b0, 8'h7f, 32'h0);
    chk("unmapped", {31'h0, slvErr}, 32'h1);
  endtask : t_regs
  // Each flag on its own bit; the last pass clears them all.
  task automatic t_status();
    for (int b = 0; b < 6; b++) begin
      {enc.coordUnset, enc.puuOvf, enc.turnOvf, enc.battLow, enc.absLost}
        <= 5'h1 << b;
      rdc("status", `APSC_IDX_STATUS, {27'h0, 5'h1 << b});
    end
  endtask : t_status
  // Renew in pulse units, then user units; only 2 pulses the loop.
  task automatic t_renew();
    enc.turns <= 16'h8000;
    enc.pulse <= 32'h0001_f3a5;
    enc.userPos <= 32'h8000_0001;
    xfer(1'b1, `APSC_IDX_RENEW, 32'h1);
    rdc("turn", `APSC_IDX_TURN, 32'hffff_8000);
    rdc("single", `APSC_IDX_SINGLE, 32'h0001_f3a5);
    chk("pulse one", pulseCnt, 32'h0);
    xfer(1'b1, `APSC_IDX_RENEW, 32'h2);
    xfer(1'b1, `APSC_IDX_UNITSEL, 32'h2);
    chk("pulse two", pulseCnt, 32'h1);
    xfer(1'b1, `APSC_IDX_RENEW, 32'h1);
    rdc("turn user", `APSC_IDX_TURN, 32'h0);
    rdc("single user", `APSC_IDX_SINGLE, 32'h8000_0001);
  endtask : t_renew
  // Hold in window for 2 ms of 4 cycles, restart on re-entry, interrupt.
  task automatic t_filter();
    xfer(1'b1, `APSC_IDX_IRQSTAT, 32'hf);
    xfer(1'b1, `APSC_IDX_LOWER, 32'd10);
    xfer(1'b1, `APSC_IDX_UPPER, 32'd20);
    xfer(1'b1, `APSC_IDX_FTIME, 32'h2);
    monVar <= 32'd5;
    repeat (3) @(posedge clk);
    chk("pass", filtOut, 32'd5);
    monVar <= 32'd15;
    repeat (3) @(posedge clk);
    chk("hold", filtOut, 32'd5);
    monVar <= 32'd30;
    repeat (3) @(posedge clk);
    chk("leave", filtOut, 32'd30);
    monVar <= 32'd12;
    repeat (6) @(posedge clk);
    chk("restart", filtOut, 32'd30);
    repeat (9) @(posedge clk);
    chk("release", filtOut, 32'd12);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdc("irq stat", `APSC_IDX_IRQSTAT, 32'h2);
    xfer(1'b1, `APSC_IDX_IRQMASK, 32'h2);
    rdc("filt reg", `APSC_IDX_FILTOUT, 32'd12);
    chk("irq on", {31'h0, irq}, 32'h1);
    xfer(1'b1, `APSC_IDX_IRQSTAT, 32'h2);
    rdc("irq clr", `APSC_IDX_IRQSTAT, 32'h0);
    chk("irq off", {31'h0, irq}, 32'h0);
  endtask : t_filter
  // Main sequence; first transfer waits out the internal reset.
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    apbReq = '0;
    enc = '0;
    monVar = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_status();
    t_renew();
    t_filter();
    close_out();
  end
  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    close_out();
  end
endmodule : apsc_top_tb
